// [sblu_pkg.sv]
/*
  Package for the single-bit logic unit: operation codes, operand width,
  field widths, register count, the three-bit bit-number mask and the byte-wide constants.
  Assumes a core that decodes instructions and supplies operands each cycle.
*/
package sblu_pkg;
  localparam int BYTE_W = 8;
  localparam int BITNO_W = 3;
  localparam int REG_IDX_W = 4;
  localparam int NUM_REGS = 16;
  localparam logic [BITNO_W-1:0] BITNO_LSB_MASK = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] ONE_HOT_BASE = 8'h01;

  typedef enum logic [2:0] {
    OP_BIT_INVERT,
    OP_BIT_TEST,
    OP_CARRY_AND,
    OP_CARRY_AND_INV,
    OP_CARRY_OR,
    OP_CARRY_OR_INV
  } sblu_op_e;

  typedef logic [BYTE_W-1:0] sblu_byte_t;
  typedef logic [BITNO_W-1:0] sblu_bitno_t;
  typedef logic [REG_IDX_W-1:0] sblu_ridx_t;
endpackage : sblu_pkg

// [sblu_regs_if.sv]
/*
  Interface between the unit and its general register file.
  Assumes one read port for the operand, one for the bit number, one write port.
*/
interface sblu_regs_if;
  import sblu_pkg::*;
  sblu_ridx_t opIdx;
  sblu_ridx_t bitIdx;
  sblu_byte_t opData;
  sblu_byte_t bitData;
  logic wrEn;
  sblu_ridx_t wrIdx;
  sblu_byte_t wrData;
  modport unit (output opIdx, output bitIdx, output wrEn, output wrIdx, output wrData,
                input opData, input bitData);
  modport regs (input opIdx, input bitIdx, input wrEn, input wrIdx, input wrData,
                output opData, output bitData);
endinterface : sblu_regs_if

// [sblu_reg_file.sv]
/*
  General register file, byte wide, with registered read data.
  Assumes reads issued one cycle before the data are used.
*/
module sblu_reg_file #(
  parameter int NREGS = sblu_pkg::NUM_REGS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  sblu_regs_if.regs rf
);
  import sblu_pkg::*;

  typedef struct packed {
    logic [NREGS-1:0][BYTE_W-1:0] mem;
    sblu_byte_t opData;
    sblu_byte_t bitData;
  } sblu_rf_s;

  sblu_rf_s state_reg;
  sblu_rf_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.opData = state_reg.mem[rf.opIdx];
    state_next.bitData = state_reg.mem[rf.bitIdx];
    if (rf.wrEn) begin
      state_next.mem[rf.wrIdx] = rf.wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rf.opData = state_reg.opData;
  assign rf.bitData = state_reg.bitData;
endmodule : sblu_reg_file

// [sblu_unit.sv]
/*
  Single-bit logic unit: invert, test, and carry AND/OR on one bit of a byte.
  Assumes the core holds a request until done and owns the memory bus timing.
*/
// How it works
// RULE1 - invert flips the chosen bit and writes the byte back, other bits kept
// RULE2 - invert bit number from immediate or low three bits of a register
// RULE3 - test loads zero flag with the inverse of the chosen bit
// RULE4 - test bit number from immediate or low three bits of a register
// RULE5 - carry AND: carry becomes carry and chosen bit
// RULE6 - inverted carry AND: carry becomes carry and inverse of chosen bit
// RULE7 - carry OR: carry becomes carry or chosen bit
// RULE8 - inverted carry OR: carry becomes carry or inverse of chosen bit
// RULE9 - carry operations take their bit number from the immediate only
// RULE10 - operand comes from a general register or a memory byte
// RULE11 - all operands are bytes; memory invert is one byte read-modify-write
// RULE12 - test and carry operations never write the operand back
module sblu_unit (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire sblu_pkg::sblu_op_e reqOp,
  input wire logic useMem,
  input wire sblu_pkg::sblu_ridx_t opReg,
  input wire logic bitFromReg,
  input wire sblu_pkg::sblu_ridx_t bitReg,
  input wire sblu_pkg::sblu_bitno_t bitImm,
  input wire logic carryIn,
  input wire logic zeroIn,
  input wire logic memReady,
  input wire sblu_pkg::sblu_byte_t memRdData,
  output logic busy,
  output logic done,
  output logic carryOut,
  output logic zeroOut,
  output logic carryWe,
  output logic zeroWe,
  output logic memRdReq,
  output logic memWrReq,
  output sblu_pkg::sblu_byte_t memWrData
);
  import sblu_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REG_RD,
    ST_MEM_RD,
    ST_EXEC,
    ST_MEM_WR
  } sblu_state_e;

  typedef struct packed {
    sblu_state_e st;
    sblu_op_e op;
    logic useMem;
    sblu_ridx_t opReg;
    logic bitFromReg;
    sblu_bitno_t bitImm;
    logic carry;
    logic zero;
    sblu_byte_t operand;
    logic busy;
    logic done;
    logic carryOut;
    logic zeroOut;
    logic carryWe;
    logic zeroWe;
    logic memRdReq;
    logic memWrReq;
    sblu_byte_t memWrData;
    logic rfWe;
    sblu_byte_t rfWrData;
  } sblu_unit_s;

  sblu_unit_s state_reg;
  sblu_unit_s state_next;

  sblu_regs_if regs ();

  sblu_reg_file u_regs (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .rf(regs.regs)
  );

  function automatic logic pickBit(input sblu_byte_t v, input sblu_bitno_t n);
    pickBit = v[n];
  endfunction : pickBit

  function automatic sblu_byte_t bitMask(input sblu_bitno_t n);
    bitMask = ONE_HOT_BASE << n;
  endfunction : bitMask

  sblu_bitno_t bitNo;
  logic selBit;

  // register source only honoured for invert and test [RULE2] [RULE4] [RULE9]
  always_comb begin
    if (state_reg.bitFromReg &&
        (state_reg.op == OP_BIT_INVERT || state_reg.op == OP_BIT_TEST)) begin
      bitNo = regs.bitData[BITNO_W-1:0] & BITNO_LSB_MASK;
    end else begin
      bitNo = state_reg.bitImm;
    end
  end

  assign selBit = pickBit(state_reg.operand, bitNo);

  assign regs.opIdx = state_reg.opReg;
  assign regs.bitIdx = bitReg;
  assign regs.wrEn = state_reg.rfWe;
  assign regs.wrIdx = state_reg.opReg;
  assign regs.wrData = state_reg.rfWrData;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.carryWe = 1'b0;
    state_next.zeroWe = 1'b0;
    state_next.rfWe = 1'b0;
    case (state_reg.st)
      ST_IDLE: begin
        if (reqValid) begin
          state_next.op = reqOp;
          state_next.useMem = useMem;
          state_next.opReg = opReg;
          state_next.bitFromReg = bitFromReg;
          state_next.bitImm = bitImm;
          state_next.carry = carryIn;
          state_next.zero = zeroIn;
          state_next.busy = 1'b1;
          // operand source: memory byte or general register [RULE10]
          if (useMem) begin
            state_next.memRdReq = 1'b1;
            state_next.st = ST_MEM_RD;
          end else begin
            state_next.st = ST_REG_RD;
          end
        end
      end
      ST_REG_RD: begin
        // read data registered one cycle; bit register read in step
        state_next.st = ST_EXEC;
      end
      ST_MEM_RD: begin
        if (memReady) begin
          state_next.memRdReq = 1'b0;
          state_next.operand = memRdData;
          state_next.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (!state_reg.useMem) begin
          state_next.operand = regs.opData;
        end
        state_next.st = ST_IDLE;
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        case (state_reg.op)
          OP_BIT_INVERT: begin
            // only the chosen bit flips, one byte written [RULE1] [RULE11]
            if (state_reg.useMem) begin
              state_next.memWrData = state_reg.operand ^ bitMask(bitNo);
              state_next.memWrReq = 1'b1;
              state_next.st = ST_MEM_WR;
              state_next.busy = 1'b1;
              state_next.done = 1'b0;
            end else begin
              state_next.rfWrData = regs.opData ^ bitMask(bitNo);
              state_next.rfWe = 1'b1;
            end
          end
          OP_BIT_TEST: begin
            state_next.zeroOut = ~pickBit(state_reg.useMem ? state_reg.operand : regs.opData,
                                          bitNo); // [RULE3] [RULE12]
            state_next.zeroWe = 1'b1;
          end
          OP_CARRY_AND: begin
            state_next.carryOut = state_reg.carry &
              pickBit(state_reg.useMem ? state_reg.operand : regs.opData, bitNo); // [RULE5]
            state_next.carryWe = 1'b1;
          end
          OP_CARRY_AND_INV: begin
            state_next.carryOut = state_reg.carry &
              ~pickBit(state_reg.useMem ? state_reg.operand : regs.opData, bitNo); // [RULE6]
            state_next.carryWe = 1'b1;
          end
          OP_CARRY_OR: begin
            state_next.carryOut = state_reg.carry |
              pickBit(state_reg.useMem ? state_reg.operand : regs.opData, bitNo); // [RULE7]
            state_next.carryWe = 1'b1;
          end
          OP_CARRY_OR_INV: begin
            state_next.carryOut = state_reg.carry |
              ~pickBit(state_reg.useMem ? state_reg.operand : regs.opData, bitNo); // [RULE8]
            state_next.carryWe = 1'b1;
          end
          default: begin
            state_next.carryWe = 1'b0;
          end
        endcase
      end
      ST_MEM_WR: begin
        // write-back completes the read-modify-write [RULE11]
        if (memReady) begin
          state_next.memWrReq = 1'b0;
          state_next.busy = 1'b0;
          state_next.done = 1'b1;
          state_next.st = ST_IDLE;
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;
  assign carryOut = state_reg.carryOut;
  assign zeroOut = state_reg.zeroOut;
  assign carryWe = state_reg.carryWe;
  assign zeroWe = state_reg.zeroWe;
  assign memRdReq = state_reg.memRdReq;
  assign memWrReq = state_reg.memWrReq;
  assign memWrData = state_reg.memWrData;
endmodule : sblu_unit

// [sblu_unit_properties.sv]
/* port checker for sblu_unit
   bound from the bench top; sees the unit's ports only */
module sblu_unit_chk import sblu_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire sblu_op_e reqOp,
  input wire logic useMem,
  input wire logic bitFromReg,
  input wire sblu_bitno_t bitImm,
  input wire logic carryIn,
  input wire logic memReady,
  input wire sblu_byte_t memRdData,
  input wire logic busy,
  input wire logic done,
  input wire logic carryOut,
  input wire logic zeroOut,
  input wire logic carryWe,
  input wire logic zeroWe,
  input wire logic memRdReq,
  input wire logic memWrReq,
  input wire sblu_byte_t memWrData
);
  timeunit 1ns;
  timeprecision 100ps;
  sblu_op_e opL;
  logic memL, regL, cL, bitV, expC;
  sblu_bitno_t bitL;
  sblu_byte_t rdL;
  always_ff @(posedge sys_clk) begin
    if (reqValid && !busy) begin
      {opL, memL, regL, bitL, cL} <= {reqOp, useMem, bitFromReg, bitImm, carryIn};
    end
    if (memRdReq && memReady) begin
      rdL <= memRdData;
    end
  end
  assign bitV = rdL[bitL];
  always_comb begin
    case (opL)
      OP_CARRY_AND: expC = cL & bitV;
      OP_CARRY_AND_INV: expC = cL & ~bitV;
      OP_CARRY_OR: expC = cL | bitV;
      default: expC = cL | ~bitV;
    endcase
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_done_pulse: assert property (done |=> !done) else $error("done too long");
  chk_done_idle: assert property (done |-> !busy) else $error("busy at done");
  chk_reg_latency: assert property (reqValid && !busy && !useMem |-> ##[2:3] done)
    else $error("register op late");
  chk_reg_no_mem: assert property (reqValid && !busy && !useMem |=> !memRdReq [*2])
    else $error("memory read on register op");
  chk_rd_hold: assert property (memRdReq && !memReady |=> memRdReq)
    else $error("read request dropped");
  chk_wr_only_inv: assert property (memWrReq |-> opL == OP_BIT_INVERT)
    else $error("write on non invert");
  chk_inv_byte: assert property (memWrReq && !regL |-> memWrData == (rdL ^ (ONE_HOT_BASE << bitL)))
    else $error("bad write byte");
  chk_test_zero: assert property (zeroWe && memL && !regL |-> zeroOut == ~bitV)
    else $error("bad zero");
  chk_zero_src: assert property (zeroWe |-> opL == OP_BIT_TEST)
    else $error("zero on wrong op");
  chk_carry_value: assert property (carryWe && memL |-> carryOut == expC)
    else $error("bad carry");
  cover property (memWrReq && memReady);
  cover property (zeroWe && zeroOut);
  cover property (carryWe && carryOut);
endmodule : sblu_unit_chk

// [sblu_unit_bench.sv]
/* self-checking bench for sblu_unit
   assumes the package and the unit are compiled first */
module sblu_unit_bench import sblu_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, reset_n = 0, reqValid = 0, useMem = 0, bitFromReg = 0;
  logic carryIn = 0, zeroIn = 0, memReady = 0;
  sblu_op_e reqOp = OP_BIT_TEST;
  sblu_ridx_t opReg = 4'h0, bitReg = 4'h0;
  sblu_bitno_t bitImm = 3'h0;
  sblu_byte_t memRdData = 8'h00, memWrData, gotW;
  logic busy, done, carryOut, zeroOut, carryWe, zeroWe, memRdReq, memWrReq;
  logic gotC, gotZ, sawRd, sawWr, rq;
  int errors = 0, cmp_count = 0, cycles = 0;
  sblu_op_e ops [4] = '{OP_CARRY_AND, OP_CARRY_AND_INV, OP_CARRY_OR, OP_CARRY_OR_INV};
  sblu_unit DUT (.sys_clk, .reset_n, .reqValid, .reqOp, .useMem, .opReg, .bitFromReg,
    .bitReg, .bitImm, .carryIn, .zeroIn, .memReady, .memRdData, .busy, .done, .carryOut,
    .zeroOut, .carryWe, .zeroWe, .memRdReq, .memWrReq, .memWrData);
  always #2.5 sys_clk = ~sys_clk;
  // whole run is under two hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test;
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task chk(input string n, input sblu_byte_t e, input sblu_byte_t g);
    cmp_count++;
    if (e !== g) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic run(input sblu_op_e op, input logic m, input sblu_ridx_t r,
      input logic fr, input sblu_ridx_t br, input sblu_bitno_t imm, input logic c,
      input sblu_byte_t rd);
    {gotC, gotZ, gotW, sawRd, sawWr} = {2'bxx, 8'hxx, 2'b00};
    @(posedge sys_clk);
    {reqValid, reqOp, useMem, opReg, bitFromReg, bitReg, bitImm} <= {1'b1, op, m, r, fr, br, imm};
    carryIn <= c;
    zeroIn <= ~c;
    @(posedge sys_clk);
    reqValid <= 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (zeroWe === 1'b1) gotZ = zeroOut;
      if (carryWe === 1'b1) gotC = carryOut;
      if (memWrReq === 1'b1) {sawWr, gotW} = {1'b1, memWrData};
      if (memRdReq === 1'b1) sawRd = 1;
      if (done === 1'b1) break;
      rq = memRdReq | memWrReq;
      @(posedge sys_clk);
      // answer one cycle late; read lines show garbage outside a read
      memReady <= rq && !memReady;
      memRdData <= (rq && !memReady) ? rd : ~rd;
    end
    chk("done", 8'h01, {7'h00, done});
  endtask : run
  task t_mem_invert;
    run(OP_BIT_INVERT, 1, 4'h0, 0, 4'h0, 3'h7, 0, 8'h5a);
    chk("imm invert", 8'hda, gotW);
    run(OP_BIT_INVERT, 1, 4'h0, 1, 4'h2, 3'h7, 0, 8'h5a);
    chk("reg bit invert", 8'h5b, gotW);
  endtask : t_mem_invert
  task t_mem_test;
    run(OP_BIT_TEST, 1, 4'h0, 0, 4'h0, 3'h3, 0, 8'h08);
    chk("zero bit one", 8'h00, {7'h00, gotZ});
    chk("test no write", 8'h00, {7'h00, sawWr});
    run(OP_BIT_TEST, 1, 4'h0, 0, 4'h0, 3'h2, 1, 8'h08);
    chk("zero bit zero", 8'h01, {7'h00, gotZ});
  endtask : t_mem_test
  task t_carry;
    logic e;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        // k[0] is carry, k[1] the bit; register bit number must be ignored
        run(ops[i], 1, 4'h0, k[0], 4'h2, k[1] ? 3'h4 : 3'h5, k[0], 8'h10);
        case (i)
          0: e = k[0] & k[1];
          1: e = k[0] & ~k[1];
          2: e = k[0] | k[1];
          default: e = k[0] | ~k[1];
        endcase
        chk("carry", {7'h00, e}, {7'h00, gotC});
        chk("carry no write", 8'h00, {7'h00, sawWr});
      end
    end
  endtask : t_carry
  task t_reg;
    run(OP_BIT_INVERT, 0, 4'h3, 0, 4'h0, 3'h5, 0, 8'h00);
    run(OP_BIT_TEST, 0, 4'h3, 0, 4'h0, 3'h5, 0, 8'hff);
    chk("reg invert", 8'h00, {7'h00, gotZ});
    run(OP_BIT_INVERT, 0, 4'h1, 0, 4'h0, 3'h0, 0, 8'h00);
    run(OP_BIT_INVERT, 0, 4'h1, 0, 4'h0, 3'h2, 0, 8'h00);
    run(OP_BIT_TEST, 0, 4'h3, 1, 4'h1, 3'h0, 0, 8'h00);
    chk("reg bit test", 8'h00, {7'h00, gotZ});
    run(OP_CARRY_AND, 0, 4'h3, 0, 4'h0, 3'h5, 1, 8'h00);
    chk("reg carry", 8'h01, {7'h00, gotC});
    chk("reg no read", 8'h00, {7'h00, sawRd});
  endtask : t_reg
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1;
    t_mem_invert();
    t_mem_test();
    t_carry();
    t_reg();
    end_of_test();
  end
endmodule : sblu_unit_bench
bind sblu_unit sblu_unit_chk CHK (.sys_clk, .reset_n, .reqValid, .reqOp, .useMem,
  .bitFromReg, .bitImm, .carryIn, .memReady, .memRdData, .busy, .done, .carryOut,
  .zeroOut, .carryWe, .zeroWe, .memRdReq, .memWrReq, .memWrData);
